//--- logic/ccw_cfg.svh
// ccw_cfg.svh: offsets, field positions, reset values for the core control word
// assumes inclusion by the package, the register bank and the assertion module only
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH
`define CCW_ADDR_CTRL 4'h0
`define CCW_ADDR_CORE 4'h4
`define CCW_ADDR_W 4
`define CCW_BIT_LAT 15
`define CCW_BIT_UNIMP 14
`define CCW_MSM_HI 13
`define CCW_MSM_LO 12
`define CCW_BIT_ELX 11
`define CCW_LND_HI 10
`define CCW_LND_LO 8
`define CCW_BIT_CA 7
`define CCW_BIT_CB 6
`define CCW_BIT_CS 5
`define CCW_BIT_CW 4
`define CCW_BIT_PLM 3
`define CCW_RESET 16'h0020
`define CCW_MSM_SIGNED 2'h0
`define CCW_MSM_UNSIGNED 2'h1
`define CCW_MSM_RESV 2'h3
`define CCW_RESP_OKAY 2'h0
`define CCW_RESP_SLVERR 2'h2
`endif

//--- logic/ccw_core_ctrl.sv
// ccw_core_ctrl.sv: core control word register bank, axi4-lite slave
// assumes core drives loop depth, status priority bits and msb load each cycle
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"
module ccw_core_ctrl import ccw_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [`CCW_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`CCW_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [2:0] i_loop_nest_depth,
  input wire logic [2:0] i_priority_level_low,
  input wire logic i_core_msb,
  input wire logic i_core_msb_load,
  output logic o_latency_variable,
  output ccw_mul_mode_t o_multiply_sign_mode,
  output logic o_early_loop_exit,
  output logic o_acc_a_clamp_enable,
  output logic o_acc_b_clamp_enable,
  output logic o_store_clamp_enable,
  output logic o_clamp_width_select,
  output logic [3:0] o_priority_level
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  ccw_prio_if prio ();
  ccw_wst_t wst_r;
  logic aw_got_r;
  logic w_got_r;
  logic [`CCW_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [1:0] wstrb_r;
  logic [15:0] ccw_r;
  logic elx_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [15:0] rd_word;
  logic wr_fire;
  logic wr_hit;
  logic [15:0] wr_val;

  ccw_prio_track u_prio (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_core_msb(i_core_msb),
    .i_core_msb_load(i_core_msb_load),
    .prio(prio.track)
  );

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data taken in either order, response once both are in
  assign o_awready = (wst_r == CCW_W_IDLE) && !aw_got_r;
  assign o_wready = (wst_r == CCW_W_IDLE) && !w_got_r;
  assign wr_fire = (wst_r == CCW_W_IDLE) && (aw_got_r || i_awvalid) && (w_got_r || i_wvalid);
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_got_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_got_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb[1:0];
      end
    end
  end

  logic [`CCW_ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [1:0] ws;
  assign wa = aw_got_r ? awaddr_r : i_awaddr;
  assign wd = w_got_r ? wdata_r : i_wdata;
  assign ws = w_got_r ? wstrb_r : i_wstrb[1:0];
  assign wr_hit = wr_fire && (wa == `CCW_ADDR_CTRL);
  // byte lanes merge into the held word; word access is the intended use
  assign wr_val = {ws[1] ? wd[15:8] : ccw_r[15:8], ws[0] ? wd[7:0] : ccw_r[7:0]};

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wst_r <= CCW_W_IDLE;
      bresp_r <= `CCW_RESP_OKAY;
    end else begin
      unique case (wst_r)
        CCW_W_IDLE: begin
          if (wr_fire) begin
            wst_r <= CCW_W_RESP;
            bresp_r <= (wa == `CCW_ADDR_CTRL || wa == `CCW_ADDR_CORE) ?
                       `CCW_RESP_OKAY : `CCW_RESP_SLVERR;
          end
        end
        CCW_W_RESP: begin
          if (i_bready) begin
            wst_r <= CCW_W_IDLE;
          end
        end
      endcase
    end
  end
  assign o_bvalid = (wst_r == CCW_W_RESP);
  assign o_bresp = bresp_r;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ccw_r <= `CCW_RESET;
    end else if (wr_hit) begin
      ccw_r[`CCW_BIT_LAT] <= wr_val[`CCW_BIT_LAT];
      ccw_r[`CCW_MSM_HI:`CCW_MSM_LO] <= wr_val[`CCW_MSM_HI:`CCW_MSM_LO];
      ccw_r[`CCW_BIT_CA] <= wr_val[`CCW_BIT_CA];
      ccw_r[`CCW_BIT_CB] <= wr_val[`CCW_BIT_CB];
      ccw_r[`CCW_BIT_CS] <= wr_val[`CCW_BIT_CS];
      ccw_r[`CCW_BIT_CW] <= wr_val[`CCW_BIT_CW];
    end
  end

  // one-cycle exit request; writing zero does nothing
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      elx_r <= 1'b0;
    end else begin
      elx_r <= wr_hit && ws[1] && wd[`CCW_BIT_ELX];
    end
  end

  // clear of the msb only when software writes zero there
  assign prio.clr_msb = wr_hit && ws[0] && !wd[`CCW_BIT_PLM];

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    rd_word[`CCW_BIT_LAT] = ccw_r[`CCW_BIT_LAT];
    rd_word[`CCW_MSM_HI:`CCW_MSM_LO] = ccw_r[`CCW_MSM_HI:`CCW_MSM_LO];
    rd_word[`CCW_LND_HI:`CCW_LND_LO] = i_loop_nest_depth;
    rd_word[`CCW_BIT_CA] = ccw_r[`CCW_BIT_CA];
    rd_word[`CCW_BIT_CB] = ccw_r[`CCW_BIT_CB];
    rd_word[`CCW_BIT_CS] = ccw_r[`CCW_BIT_CS];
    rd_word[`CCW_BIT_CW] = ccw_r[`CCW_BIT_CW];
    rd_word[`CCW_BIT_PLM] = prio.msb;
  end

  assign o_arready = !rvalid_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `CCW_RESP_OKAY;
    end else if (i_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      if (i_araddr == `CCW_ADDR_CTRL) begin
        rdata_r <= {16'h0000, rd_word};
        rresp_r <= `CCW_RESP_OKAY;
      end else if (i_araddr == `CCW_ADDR_CORE) begin
        rdata_r <= {28'h0000000, prio.msb, i_priority_level_low};
        rresp_r <= `CCW_RESP_OKAY;
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `CCW_RESP_SLVERR;
      end
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  // ----------------------------------------
  // core facing outputs
  // ----------------------------------------
  assign o_latency_variable = ccw_r[`CCW_BIT_LAT];
  assign o_multiply_sign_mode = ccw_mul_mode_t'(ccw_r[`CCW_MSM_HI:`CCW_MSM_LO]);
  assign o_early_loop_exit = elx_r;
  assign o_acc_a_clamp_enable = ccw_r[`CCW_BIT_CA];
  assign o_acc_b_clamp_enable = ccw_r[`CCW_BIT_CB];
  assign o_store_clamp_enable = ccw_r[`CCW_BIT_CS];
  assign o_clamp_width_select = ccw_r[`CCW_BIT_CW];
  assign o_priority_level = {prio.msb, i_priority_level_low};
endmodule : ccw_core_ctrl
`default_nettype wire

//--- logic/ccw_pkg.sv
// ccw_pkg.sv: types of the core control register bank
// assumes ccw_cfg.svh on the include path
`include "ccw_cfg.svh"
package ccw_pkg;
  typedef enum logic [1:0] {
    CCW_MUL_SIGNED = `CCW_MSM_SIGNED,
    CCW_MUL_UNSIGNED = `CCW_MSM_UNSIGNED,
    CCW_MUL_RESV = `CCW_MSM_RESV
  } ccw_mul_mode_t;
  typedef enum logic [1:0] {
    CCW_W_IDLE = 2'b01,
    CCW_W_RESP = 2'b10
  } ccw_wst_t;
endpackage : ccw_pkg

//--- logic/ccw_prio_if.sv
// ccw_prio_if.sv: priority level handshake between bank and priority tracker
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface ccw_prio_if;
  logic clr_msb;
  logic msb;
  modport bank (output clr_msb, input msb);
  modport track (input clr_msb, output msb);
endinterface : ccw_prio_if
`default_nettype wire

//--- logic/ccw_prio_track.sv
// ccw_prio_track.sv: holds the priority level msb, set only by the core
// assumes core set request is a level from the core pipeline
`timescale 1ns/10ps
`default_nettype none
module ccw_prio_track (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_core_msb,
  input wire logic i_core_msb_load,
  ccw_prio_if.track prio
);
  logic msb_r;
  // core load wins over software clear; software can only clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      msb_r <= 1'b0;
    end else if (i_core_msb_load) begin
      msb_r <= i_core_msb;
    end else if (prio.clr_msb) begin
      msb_r <= 1'b0;
    end
  end
  assign prio.msb = msb_r;
endmodule : ccw_prio_track
`default_nettype wire

//--- tb/ccw_core_ctrl_assertions.sv
// ccw_core_ctrl_assertions.sv: port checks of the control word bank
// assumes one clock and that aw and w of a write are offered together
`timescale 1ns/10ps
`default_nettype none
`include "ccw_cfg.svh"
module ccw_core_ctrl_assertions (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [`CCW_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [`CCW_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [2:0] i_loop_nest_depth,
  input wire logic [2:0] i_priority_level_low,
  input wire logic i_core_msb_load,
  input wire logic o_latency_variable,
  input wire logic o_early_loop_exit,
  input wire logic [3:0] o_priority_level
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire logic wr_hit = i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb[1]
    && i_awaddr == `CCW_ADDR_CTRL;
  sequence rd_ctl;
    i_arvalid && o_arready && i_araddr == `CCW_ADDR_CTRL;
  endsequence
  sequence exit_pulse;
    o_early_loop_exit ##1 !o_early_loop_exit;
  endsequence
  lat_write_a: assert property (wr_hit |=> o_bvalid && o_latency_variable == $past(i_wdata[15]))
    else $error("latency bit missed write");
  exit_pulse_a: assert property (wr_hit && i_wdata[11] |=> exit_pulse)
    else $error("loop exit pulse wrong");
  exit_read_a: assert property (o_rvalid |-> !o_rdata[11] && !o_rdata[14])
    else $error("exit or unused bit read one");
  depth_read_a: assert property (rd_ctl |=> o_rvalid && o_rdata[10:8] == $past(i_loop_nest_depth))
    else $error("loop depth read wrong");
  prio_join_a: assert property (o_priority_level[2:0] == i_priority_level_low)
    else $error("priority low bits wrong");
  msb_noset_a: assert property ($rose(o_priority_level[3]) |-> $past(i_core_msb_load))
    else $error("priority msb set without core");
  lat_hold_a: assert property (!wr_hit |=> $stable(o_latency_variable))
    else $error("latency bit moved without write");
  rd_hold_a: assert property (o_rvalid && i_rready |=> !o_rvalid && $stable(o_rdata))
    else $error("read not closed or data moved");
endmodule : ccw_core_ctrl_assertions
bind ccw_core_ctrl ccw_core_ctrl_assertions u_ccw_core_ctrl_assertions (.*);
`default_nettype wire

//--- tb/tb_top.sv
// tb_top.sv: self-checking bench of the control word bank
// assumes the bank answers each request in fewer than 64 cycles
`timescale 1ns/10ps
`default_nettype none
module tb_top import ccw_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
  logic rre = 1'b0, msb = 1'b0, msbl = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [2:0] dep = 3'h0, pl = 3'h0;
  logic [1:0] rres;
  wire logic aw_r, w_r, bv, ar_r, rv, lat, ex, ca, cb, cs, cw;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  wire logic [3:0] prio;
  ccw_mul_mode_t mode;
  int fail_count = 0, tests_run = 0, ex_cnt = 0;
  ccw_core_ctrl u_ccw_core_ctrl (.i_ref_clk(clk), .i_resetn(rstn), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(aw_r), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv),
    .o_wready(w_r), .o_bresp(br), .o_bvalid(bv), .i_bready(bre), .i_araddr(ara),
    .i_arvalid(arv), .o_arready(ar_r), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv),
    .i_rready(rre), .i_loop_nest_depth(dep), .i_priority_level_low(pl), .i_core_msb(msb),
    .i_core_msb_load(msbl), .o_latency_variable(lat), .o_multiply_sign_mode(mode),
    .o_early_loop_exit(ex), .o_acc_a_clamp_enable(ca), .o_acc_b_clamp_enable(cb),
    .o_store_clamp_enable(cs), .o_clamp_width_select(cw), .o_priority_level(prio));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (ex === 1'b1) ex_cnt <= ex_cnt + 1;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic guard(input int n);
    if (n >= 64) begin
      fail_count++;
      end_sim();
    end
  endtask : guard
  // ---------------------------------------
  // bus tasks, entered just after an edge
  // ---------------------------------------
  task automatic axw(input logic [3:0] a, input logic [15:0] d, input logic [1:0] s);
    int n = 0;
    awa <= a;
    wd <= {16'h0000, d};
    ws <= {2'b00, s};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw_r) awv <= 1'b0;
      if (w_r) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 64);
    // bready stays up between writes, so it is never lowered and raised in one step
    guard(n);
    chk("bresp", 32'(br), (a == 4'h0 || a == 4'h4) ? 32'h0 : 32'h2);
  endtask : axw
  task automatic axr(input logic [3:0] a);
    int n = 0;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (ar_r) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 64);
    rdat = rd;
    rres = rr;
    guard(n);
  endtask : axr
  task automatic t_reset;
    axr(4'h0);
    chk("reset word", rdat, 32'h0020);
    chk("reset fields", 32'({lat, ca, cb, cs, cw}), 32'h02);
  endtask : t_reset
  task automatic t_ones;
    dep <= 3'h5;
    axw(4'h0, 16'hffff, 2'b11);
    chk("fields set", 32'({lat, ca, cb, cs, cw}), 32'h1f);
    axr(4'h0);
    chk("word ones", rdat, 32'hb5f0);
    chk("exit pulses", ex_cnt, 32'h1);
  endtask : t_ones
  task automatic t_zero;
    axw(4'h0, 16'h0000, 2'b11);
    chk("fields clear", 32'({lat, ca, cb, cs, cw}), 32'h00);
    axr(4'h0);
    chk("no exit pulse", ex_cnt, 32'h1);
  endtask : t_zero
  task automatic t_modes;
    logic [1:0] m [3] = '{2'h0, 2'h1, 2'h3};
    foreach (m[i]) begin
      axw(4'h0, {2'b00, m[i], 12'h000}, 2'b10);
      chk("sign mode", 32'(mode), 32'(m[i]));
    end
  endtask : t_modes
  task automatic t_prio;
    pl <= 3'h6;
    dep <= 3'h7;
    msb <= 1'b1;
    msbl <= 1'b1;
    @(posedge clk);
    msbl <= 1'b0;
    @(posedge clk);
    chk("prio level", 32'(prio), 32'he);
    axr(4'h4);
    chk("core word", rdat, 32'he);
    axr(4'h0);
    chk("ctl word", rdat, 32'h3708);
    axw(4'h0, 16'h0000, 2'b01);
    chk("msb cleared", 32'(prio), 32'h6);
  endtask : t_prio
  task automatic t_unmapped;
    axr(4'h8);
    chk("unmapped resp", 32'(rres), 32'h2);
    chk("unmapped data", rdat, 32'h0);
    axw(4'h4, 16'h0800, 2'b11);
    axw(4'h8, 16'h0800, 2'b11);
    chk("ignored exit", ex_cnt, 32'h1);
    axr(4'h4);
    chk("core word kept", rdat, 32'h6);
  endtask : t_unmapped
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ones();
    t_zero();
    t_modes();
    t_prio();
    t_unmapped();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
